// [hdl/scg_consts.svh]
// Purpose: Offsets, field positions, reset values for the sleep clock gating select.
// Assumes: Register indices are word addresses on the plain register port.
// Notes: Definitions only.
`ifndef SCG_CONSTS_SVH
`define SCG_CONSTS_SVH
`define SCG_ADDR_CLOCK_CONFIG 4'h0
`define SCG_ADDR_RUN_GATE 4'h1
`define SCG_ADDR_SLEEP_GATE 4'h2
`define SCG_ADDR_DEEP_GATE 4'h3
`define SCG_ADDR_ACTIVE_GATE 4'h4
`define SCG_ACG_BIT 27
`define SCG_CFG_WMASK 32'h0800_0000
`define SCG_CFG_RESET 32'h0000_0000
`define SCG_GATE_RESET 32'h0000_0000
`endif

// [hdl/scg_pkg.sv]
// Purpose: Types for the sleep clock gating select.
// Assumes: Power mode arrives as three one-hot codes.
// Notes: Constants live in scg_consts.svh.
package scg_pkg;
    typedef enum logic [2:0] {
        SCG_MODE_RUN = 3'h1,
        SCG_MODE_SLEEP = 3'h2,
        SCG_MODE_DEEP = 3'h4
    } scg_mode_t;
    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } scg_req_t;
endpackage

// [hdl/scg_gate_sel.sv]
// Purpose: Combinational choice of the active gating enable set.
// Assumes: Mode is one-hot; an illegal code falls back to the run set.
// Notes: No registers, so the choice follows the mode in the same cycle.
module scg_gate_sel
    import scg_pkg::*;
#(
    parameter int WIDTH = 32
) (
    input wire scg_mode_t mode_i,
    input wire logic auto_i,
    input wire logic [WIDTH-1:0] run_i,
    input wire logic [WIDTH-1:0] sleep_i,
    input wire logic [WIDTH-1:0] deep_i,
    output logic [WIDTH-1:0] sel_o
);
    always_comb begin
        case (mode_i)
            SCG_MODE_SLEEP: sel_o = auto_i ? sleep_i : run_i;
            SCG_MODE_DEEP: sel_o = auto_i ? deep_i : run_i;
            default: sel_o = run_i;
        endcase
    end
endmodule

// [hdl/scg_top.sv]
// Purpose: Register file and gate enable output for sleep clock gating select.
// Assumes: Mode input is synchronous to clk_i and one-hot.
// Notes: Gate enables leave through a flip-flop fed from the current mode.
//
// Implementation choices: the strobed register port and the register offsets.
`include "scg_consts.svh"

// Functional notes
// - Auto gating bit 27, read/write, resets 0.
// - Auto set: sleep or deep set used.
// - Auto clear: run set used when sleeping.
// - Run mode always uses run set.
module scg_top
    import scg_pkg::*;
#(
    parameter int WIDTH = 32
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire scg_mode_t mode_i,
    output logic [31:0] rdata_o,
    output logic [WIDTH-1:0] gate_en_o
);
    scg_req_t req;
    logic [31:0] cfg_q;
    logic [WIDTH-1:0] run_q;
    logic [WIDTH-1:0] sleep_q;
    logic [WIDTH-1:0] deep_q;
    logic [WIDTH-1:0] sel_d;
    logic auto_gating_select;

    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
    assign auto_gating_select = cfg_q[`SCG_ACG_BIT];

    // configuration bit storage.
    // Only the auto gating bit is writable here; the neighbouring clock fields live elsewhere.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cfg_q <= `SCG_CFG_RESET;
        end else if (req.wr && req.addr == `SCG_ADDR_CLOCK_CONFIG) begin
            cfg_q <= req.wdata & `SCG_CFG_WMASK;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            run_q <= WIDTH'(`SCG_GATE_RESET);
            sleep_q <= WIDTH'(`SCG_GATE_RESET);
            deep_q <= WIDTH'(`SCG_GATE_RESET);
        end else if (req.wr) begin
            case (req.addr)
                `SCG_ADDR_RUN_GATE: run_q <= req.wdata[WIDTH-1:0];
                `SCG_ADDR_SLEEP_GATE: sleep_q <= req.wdata[WIDTH-1:0];
                `SCG_ADDR_DEEP_GATE: deep_q <= req.wdata[WIDTH-1:0];
                default: ;
            endcase
        end
    end

    scg_gate_sel #(
        .WIDTH(WIDTH)
    ) u_sel (
        .mode_i(mode_i),
        .auto_i(auto_gating_select),
        .run_i(run_q),
        .sleep_i(sleep_q),
        .deep_i(deep_q),
        .sel_o(sel_d)
    );

    // Register current choice.
    // The flip-flop is fed from the live mode, so the gate output tracks one edge after it
    // with no extra stage that could leave a stale set in place.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            gate_en_o <= WIDTH'(`SCG_GATE_RESET);
        end else begin
            gate_en_o <= sel_d;
        end
    end

    // Unmapped addresses read zero.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (req.rd) begin
            case (req.addr)
                `SCG_ADDR_CLOCK_CONFIG: rdata_o <= cfg_q;
                `SCG_ADDR_RUN_GATE: rdata_o <= 32'(run_q);
                `SCG_ADDR_SLEEP_GATE: rdata_o <= 32'(sleep_q);
                `SCG_ADDR_DEEP_GATE: rdata_o <= 32'(deep_q);
                `SCG_ADDR_ACTIVE_GATE: rdata_o <= 32'(gate_en_o);
                default: rdata_o <= 32'h0000_0000;
            endcase
        end else begin
            rdata_o <= 32'h0000_0000;
        end
    end

    AST_CFG_RESET: assert property (@(posedge clk_i) !rst_n_i |=> cfg_q == 32'h0)
        else $error("config not cleared by reset");
    AST_CFG_WRITE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_i && addr_i == 4'h0 |=> auto_gating_select == $past(wdata_i[27]))
        else $error("auto gating bit not written");
    AST_SLEEP_AUTO: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        mode_i == SCG_MODE_SLEEP && auto_gating_select |=> gate_en_o == $past(sleep_q))
        else $error("sleep set not used");
    AST_DEEP_AUTO: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        mode_i == SCG_MODE_DEEP && auto_gating_select |=> gate_en_o == $past(deep_q))
        else $error("deep sleep set not used");
    AST_SLEEP_MANUAL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        mode_i != SCG_MODE_RUN && !auto_gating_select |=> gate_en_o == $past(run_q))
        else $error("run set not kept in sleep");
    AST_RUN_MODE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        mode_i == SCG_MODE_RUN |=> gate_en_o == $past(run_q))
        else $error("run set not used in run mode");
    AST_MODE_SWITCH: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $changed(mode_i) |=> gate_en_o == $past(sel_d))
        else $error("gate output lagged mode change");
    AST_RD_UNMAPPED: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rd_i && addr_i > 4'h4 |=> rdata_o == 32'h0)
        else $error("unmapped read not zero");
endmodule

// [bench/scg_top_tb.sv]
// Purpose: Self-checking bench for the sleep clock gating select.
// Assumes: Registered outputs, read data in the cycle after the strobe.
// Notes: Model keeps the registers as plain words.
`include "scg_consts.svh"
module scg_top_tb
    import scg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0;
    logic [3:0] addr_i = 4'h0;
    logic [31:0] wdata_i = 32'h0, rdata_o, gate_en_o, cfg_m = 0, set_m [1:3];
    scg_mode_t mode_i = SCG_MODE_RUN;
    scg_mode_t seq_m [0:6];
    int err_total = 0, compares = 0, cycles = 0, seed = 90;
    scg_top scg_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .mode_i(mode_i), .rdata_o(rdata_o), .gate_en_o(gate_en_o));
    always #5 clk_i = ~clk_i;
    // A hang stops here instead of running forever.
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_total = err_total + 1;
            results();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] pick(input scg_mode_t m);
        if (cfg_m[`SCG_ACG_BIT] && m == SCG_MODE_SLEEP) return set_m[2];
        if (cfg_m[`SCG_ACG_BIT] && m == SCG_MODE_DEEP) return set_m[3];
        return set_m[1];
    endfunction
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        chk(rdata_o, exp);
        @(negedge clk_i);
        chk(rdata_o, 32'h0);
    endtask
    task automatic results();
        if (err_total == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        set_m = '{32'h0, 32'h0, 32'h0};
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(`SCG_ADDR_CLOCK_CONFIG, `SCG_CFG_RESET);
        chk(gate_en_o, 32'h0);
        for (int k = 1; k <= 3; k++) begin
            set_m[k] = $random(seed);
            wr(k[3:0], set_m[k]);
            rd(k[3:0], set_m[k]);
        end
        rd(4'h9, 32'h0);
        seq_m = '{SCG_MODE_SLEEP, SCG_MODE_DEEP, SCG_MODE_RUN, SCG_MODE_DEEP, SCG_MODE_SLEEP,
            SCG_MODE_RUN, scg_mode_t'(3'h0)};
        for (int a = 0; a < 3; a++) begin
            wdata_i <= $random(seed);
            @(posedge clk_i);
            cfg_m = (a == 1) ? 32'hffff_ffff : wdata_i;
            wr(`SCG_ADDR_CLOCK_CONFIG, cfg_m);
            cfg_m = cfg_m & `SCG_CFG_WMASK;
            rd(`SCG_ADDR_CLOCK_CONFIG, cfg_m);
            @(posedge clk_i);
            mode_i <= seq_m[0];
            // Mode changes every cycle; each result lands one edge later.
            for (int i = 1; i < 7; i++) begin
                @(posedge clk_i);
                mode_i <= seq_m[i];
                @(negedge clk_i);
                chk(gate_en_o, pick(seq_m[i-1]));
            end
            @(posedge clk_i);
            mode_i <= SCG_MODE_DEEP;
            rd(`SCG_ADDR_ACTIVE_GATE, pick(SCG_MODE_DEEP));
        end
        results();
    end
endmodule
